// ==== sto_pkg.sv ====
package sto_pkg;
  // clock rate and timing
  localparam int unsigned STO_CLK_HZ = 40000000;
  localparam int unsigned STO_TORQUE_OFF_NS = 1000000;
  localparam int unsigned STO_MON_MS = 20;
  localparam int unsigned STO_TORQUE_OFF_CYC = STO_TORQUE_OFF_NS / 25;
  localparam int unsigned STO_MON_CYC = STO_MON_MS * (STO_CLK_HZ / 1000);
  // channel disagreement time before a channel fault is declared
  localparam int unsigned STO_DISAGREE_US = 10000;
  localparam int unsigned STO_DISAGREE_CYC = STO_DISAGREE_US * (STO_CLK_HZ / 1000000);
  // relay function code meaning "open while torque-off active"
  localparam logic [7:0] STO_RELAY_FN_STO = 8'h0D;
  // fault code of a channel fault
  localparam logic [7:0] STO_FAULT_CHANNEL = 8'h1D;
  // register byte offsets
  localparam logic [7:0] STO_REG_CTRL = 8'h00;
  localparam logic [7:0] STO_REG_STATUS = 8'h04;
  localparam logic [7:0] STO_REG_IRQ_STAT = 8'h08;
  localparam logic [7:0] STO_REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] STO_REG_RELAY_SEL = 8'h10;
  // ctrl fields
  localparam int STO_CTRL_START_BIT = 0;
  localparam int STO_CTRL_STOP_BIT = 1;
  localparam int STO_CTRL_RESET_BIT = 2;
  localparam int STO_CTRL_SRC_LSB = 4;
  // irq status bits
  localparam int STO_IRQ_ACTIVE_BIT = 0;
  localparam int STO_IRQ_FAULT_BIT = 1;
  localparam int STO_IRQ_CLEAR_BIT = 2;
  // reset values
  localparam logic [2:0] STO_IRQ_MASK_RST = 3'h0;
  localparam logic [7:0] STO_RELAY_FN_RST = 8'h00;
  localparam logic [3:0] STO_SRC_RST = 4'h0;
  // display request codes
  typedef enum logic [1:0] {
    STO_DISP_NORMAL = 2'h0,
    STO_DISP_INHIBIT = 2'h1,
    STO_DISP_TRIP = 2'h2
  } sto_disp_t;
  // drive control state, gray along standby->run->off
  typedef enum logic [1:0] {
    STO_ST_STANDBY = 2'b00,
    STO_ST_RUN = 2'b01,
    STO_ST_OFF = 2'b11
  } sto_state_t;
  // status pack shown to software
  typedef struct packed {
    logic [7:0] fault_code;
    logic [1:0] disp;
    logic [1:0] state;
    logic tripped;
    logic inhibit;
    logic energised;
    logic torque_free;
  } sto_status_t;
endpackage : sto_pkg

// ==== sto_ctrl.sv ====
// Contract
// - energised inputs: standby, start command runs drive
// - de-energised: torque off, coast, off mode
// - leave off mode after reset and re-energise
// - mains on and de-energised: request inhibit display
// - trip display beats inhibit display
// - relay1 select 13 opens relay when active
// - relay2 select 13 opens relay when active
// - channel fault raises trip code 29
// - torque free within 1 ms
// - monitoring status changes within 20 ms
// - fault shown, not-healthy output within 20 ms
// - restart allowed; no restart interlock here
// - torque-off always enabled, never configurable
//
// Implementation choices: register access over AXI4-Lite and the address map.
module sto_ctrl
  import sto_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sto_ch1,
  input wire logic sto_ch2,
  input wire logic mains_on,
  input wire logic [3:0] start_inputs,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic gate_enable,
  output logic drive_run,
  output logic relay1_closed,
  output logic relay2_closed,
  output logic not_healthy,
  output logic [1:0] display_req,
  output logic [7:0] fault_code,
  output logic irq
);

  // synchroniser stages, first stage read only by second
  logic [1:0] ch_s1_q;
  logic [1:0] ch_s2_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ch_s1_q <= 2'h0;
      ch_s2_q <= 2'h0;
    end else begin
      ch_s1_q <= {sto_ch2, sto_ch1};
      ch_s2_q <= ch_s1_q;
    end
  end

  // energised only when both channels agree high
  wire energised = &ch_s2_q;
  wire disagree = ^ch_s2_q;

  // disagreement timer flags a channel fault
  logic [18:0] dis_cnt_q;
  logic chan_fault_q;
  wire dis_done = (dis_cnt_q == 19'(STO_DISAGREE_CYC - 1));
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dis_cnt_q <= 19'h0;
    end else if (!disagree) begin
      dis_cnt_q <= 19'h0;
    end else if (!dis_done) begin
      dis_cnt_q <= dis_cnt_q + 19'h1;
    end
  end

  // register decode
  logic [31:0] ctrl_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic [7:0] relay1_fn_q;
  logic [7:0] relay2_fn_q;
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_got_q && w_got_q && !s_axi_bvalid;
  wire wr_ctrl = wr_go && (aw_addr_q == STO_REG_CTRL);
  wire wr_stat = wr_go && (aw_addr_q == STO_REG_IRQ_STAT);
  wire wr_mask = wr_go && (aw_addr_q == STO_REG_IRQ_MASK);
  wire wr_relay = wr_go && (aw_addr_q == STO_REG_RELAY_SEL);
  wire wr_hit = wr_ctrl || wr_stat || wr_mask || wr_relay;
  wire cmd_start = wr_ctrl && w_data_q[STO_CTRL_START_BIT];
  wire cmd_stop = wr_ctrl && w_data_q[STO_CTRL_STOP_BIT];
  wire cmd_reset = wr_ctrl && w_data_q[STO_CTRL_RESET_BIT];
  wire [3:0] start_src = ctrl_q[STO_CTRL_SRC_LSB +: 4];

  // start command from the selected source: 0 = register only, n = register or input (n-1) mod 4
  wire src_in = (start_src == 4'h0) ? 1'b0 : start_inputs[2'(start_src - 4'h1)];
  wire start_req = cmd_start || src_in;

  // trip latch, cleared only by fault reset when the fault is gone
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      chan_fault_q <= 1'b0;
    end else if (dis_done) begin
      chan_fault_q <= 1'b1;
    end else if (cmd_reset) begin
      chan_fault_q <= 1'b0;
    end
  end

  // drive state machine; torque-off has no disable path
  sto_state_t st_q;
  sto_state_t st_d;
  always_comb begin
    st_d = st_q;
    case (st_q)
      STO_ST_STANDBY: begin
        if (!energised || chan_fault_q) st_d = STO_ST_OFF;
        else if (start_req) st_d = STO_ST_RUN;
      end
      STO_ST_RUN: begin
        if (!energised || chan_fault_q) st_d = STO_ST_OFF;
        else if (cmd_stop) st_d = STO_ST_STANDBY;
      end
      default: begin
        if (energised && !chan_fault_q && !dis_done) st_d = STO_ST_STANDBY;
      end
    endcase
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) st_q <= STO_ST_OFF;
    else st_q <= st_d;
  end

  wire sto_active = (st_d == STO_ST_OFF);
  wire [1:0] disp_d = chan_fault_q ? STO_DISP_TRIP :
                      (mains_on && !energised) ? STO_DISP_INHIBIT :
                      STO_DISP_NORMAL;

  // outputs, all registered; gates off the cycle after de-energise seen
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      gate_enable <= 1'b0;
      drive_run <= 1'b0;
      relay1_closed <= 1'b0;
      relay2_closed <= 1'b0;
      not_healthy <= 1'b1;
      display_req <= STO_DISP_NORMAL;
      fault_code <= 8'h00;
    end else begin
      gate_enable <= (st_d == STO_ST_RUN);
      drive_run <= (st_d == STO_ST_RUN);
      relay1_closed <= !((relay1_fn_q == STO_RELAY_FN_STO) && sto_active);
      relay2_closed <= !((relay2_fn_q == STO_RELAY_FN_STO) && sto_active);
      not_healthy <= chan_fault_q;
      display_req <= disp_d;
      fault_code <= chan_fault_q ? STO_FAULT_CHANNEL : 8'h00;
    end
  end

  // interrupt events: activation, fault, inputs restored
  logic sto_active_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) sto_active_q <= 1'b1;
    else sto_active_q <= sto_active;
  end
  wire [2:0] irq_ev = {(!sto_active && sto_active_q), dis_done, (sto_active && !sto_active_q)};
  wire [2:0] clr_bits = wr_stat ? w_data_q[2:0] : 3'h0;

  // sticky status: set wins over write-one-clear
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) irq_stat_q <= 3'h0;
    else irq_stat_q <= (irq_stat_q & ~clr_bits) | irq_ev;
  end
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) irq <= 1'b0;
    else irq <= |(((irq_stat_q & ~clr_bits) | irq_ev) & irq_mask_q);
  end

  // software registers
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= {24'h0, STO_SRC_RST, 4'h0};
      irq_mask_q <= STO_IRQ_MASK_RST;
      relay1_fn_q <= STO_RELAY_FN_RST;
      relay2_fn_q <= STO_RELAY_FN_RST;
    end else begin
      if (wr_ctrl) ctrl_q <= {24'h0, w_data_q[7:4], 4'h0};
      if (wr_mask) irq_mask_q <= w_data_q[2:0];
      if (wr_relay) begin
        relay1_fn_q <= w_data_q[7:0];
        relay2_fn_q <= w_data_q[15:8];
      end
    end
  end

  // write channel capture, address and data in either order
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_got_q && !aw_fire && !s_axi_bvalid;
      s_axi_wready <= !w_got_q && !w_fire && !s_axi_bvalid;
      if (aw_fire) begin
        aw_got_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr[7:0];
      end
      if (w_fire) begin
        w_got_q <= 1'b1;
        w_data_q <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // status word
  sto_status_t stat;
  assign stat = '{fault_code: fault_code, disp: display_req, state: st_q,
                  tripped: chan_fault_q, inhibit: sto_active, energised: energised,
                  torque_free: !gate_enable};
  wire [7:0] ra = s_axi_araddr[7:0];
  wire rd_hit = (ra == STO_REG_CTRL) || (ra == STO_REG_STATUS) ||
                (ra == STO_REG_IRQ_STAT) || (ra == STO_REG_IRQ_MASK) ||
                (ra == STO_REG_RELAY_SEL);
  wire [31:0] rd_mux = (ra == STO_REG_CTRL) ? ctrl_q :
                       (ra == STO_REG_STATUS) ? {16'h0, stat} :
                       (ra == STO_REG_IRQ_STAT) ? {29'h0, irq_stat_q} :
                       (ra == STO_REG_IRQ_MASK) ? {29'h0, irq_mask_q} :
                       (ra == STO_REG_RELAY_SEL) ? {16'h0, relay2_fn_q, relay1_fn_q} :
                       32'h0;

  // read channel, one beat after address
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !ar_fire;
      if (ar_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks
  chk_gate_off_fast: assert property (@(posedge ref_clk) disable iff (reset)
    !energised |-> ##1 !gate_enable) else $error("gate not off after de-energise");
  chk_run_needs_both: assert property (@(posedge ref_clk) disable iff (reset)
    gate_enable |-> $past(energised)) else $error("gate on without both channels");
  chk_start_runs: assert property (@(posedge ref_clk) disable iff (reset)
    (st_q == STO_ST_STANDBY && energised && !chan_fault_q && start_req) |=> drive_run)
    else $error("start command ignored");
  chk_trip_code: assert property (@(posedge ref_clk) disable iff (reset)
    dis_done |=> ##1 (fault_code == STO_FAULT_CHANNEL && not_healthy))
    else $error("channel fault not reported");
  chk_trip_priority: assert property (@(posedge ref_clk) disable iff (reset)
    chan_fault_q |=> display_req == STO_DISP_TRIP) else $error("trip not displayed");
  chk_inhibit_disp: assert property (@(posedge ref_clk) disable iff (reset)
    (mains_on && !energised && !chan_fault_q) |=> display_req == STO_DISP_INHIBIT)
    else $error("inhibit not shown");
  chk_relay1_open: assert property (@(posedge ref_clk) disable iff (reset)
    (relay1_fn_q == STO_RELAY_FN_STO && !energised) |=> !relay1_closed)
    else $error("relay1 closed while active");
  chk_relay2_open: assert property (@(posedge ref_clk) disable iff (reset)
    (relay2_fn_q == STO_RELAY_FN_STO && !energised) |=> !relay2_closed)
    else $error("relay2 closed while active");
  chk_exit_needs: assert property (@(posedge ref_clk) disable iff (reset)
    (st_q == STO_ST_OFF && $past(st_q) == STO_ST_OFF && st_d != STO_ST_OFF) |->
    (energised && !chan_fault_q)) else $error("left off mode too early");
  chk_status_flag: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(energised) && st_q != STO_ST_OFF |=> irq_stat_q[STO_IRQ_ACTIVE_BIT])
    else $error("monitor status not updated");

endmodule : sto_ctrl

// ==== sto_relay_model.sv ====
// behavioural safety relay: two forcibly guided contacts feeding the torque-off channels
module sto_relay_model (
  input wire logic ref_clk,
  input wire logic energise,
  input wire logic ch1_drop,
  output logic sto_ch1,
  output logic sto_ch2
);
  timeunit 1ns;
  timeprecision 1ps;
  // contacts switch one edge after the command, like a real relay lagging its coil
  // ch1_drop opens only contact one, so the two channels disagree
  always_ff @(posedge ref_clk) begin
    sto_ch1 <= energise & ~ch1_drop;
    sto_ch2 <= energise;
  end
endmodule : sto_relay_model

// ==== tb_sto_ctrl.sv ====
module tb_sto_ctrl import sto_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, reset = 1'b1, energise = 1'b1, ch1_drop = 1'b0, mains_on = 1'b1;
  logic [3:0] start_inputs = 4'h0, wstrb = 4'hF;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rd;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sto_ch1, sto_ch2;
  logic gate_enable, drive_run, relay1_closed, relay2_closed, not_healthy, irq;
  logic [1:0] bresp, rresp, display_req, rsp;
  logic [7:0] fault_code;
  sto_status_t st; // packed view of the status word
  int n_mismatch = 0, checked = 0, cyc = 0;
  // 40 MHz clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  sto_relay_model i_sto_relay_model (.ref_clk(ref_clk), .energise(energise),
    .ch1_drop(ch1_drop), .sto_ch1(sto_ch1), .sto_ch2(sto_ch2));
  sto_ctrl i_sto_ctrl (.ref_clk(ref_clk), .reset(reset), .sto_ch1(sto_ch1), .sto_ch2(sto_ch2),
    .mains_on(mains_on), .start_inputs(start_inputs), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .gate_enable(gate_enable), .drive_run(drive_run),
    .relay1_closed(relay1_closed), .relay2_closed(relay2_closed), .not_healthy(not_healthy),
    .display_req(display_req), .fault_code(fault_code), .irq(irq));
  // verdict and end of run
  task automatic test_done();
    $display("mismatches %0d of %0d compares", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // wait n edges then let updates settle
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wt
  // axi write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic got;
    got = 1'b0;
    @(posedge ref_clk);
    awaddr <= {24'h000000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge ref_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        got = 1'b1;
        rsp = bresp;
        bready <= 1'b0;
      end
    end
  endtask : axi_wr
  // axi read: rready held until rvalid seen
  task automatic axi_rd(input logic [7:0] a);
    logic got;
    got = 1'b0;
    @(posedge ref_clk);
    araddr <= {24'h000000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge ref_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        got = 1'b1;
        rsp = rresp;
        st = rd[15:0];
        rready <= 1'b0;
      end
    end
  endtask : axi_rd
  // hang guard: the whole run needs under two hundred cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  // main sequence
  initial begin
    wt(12);
    reset <= 1'b0;
    wt(6);
    axi_rd(STO_REG_STATUS);
    check(32'(st.state), 32'(STO_ST_STANDBY));
    check(32'(gate_enable), 32'h0);
    check(32'(not_healthy), 32'h0);
    axi_wr(STO_REG_CTRL, 32'h00000001);
    check(32'(rsp), 32'h0);
    wt(3);
    check(32'(drive_run), 32'h1);
    check(32'(gate_enable), 32'h1);
    axi_wr(STO_REG_IRQ_STAT, 32'h00000007);
    axi_wr(STO_REG_IRQ_MASK, 32'h00000001);
    // pass 0: relay one selected and channel one alone drops; pass 1: relay two, both drop
    for (int k = 0; k < 2; k++) begin
      axi_wr(STO_REG_RELAY_SEL, (k == 0) ? {24'h0, STO_RELAY_FN_STO} : {16'h0, STO_RELAY_FN_STO, 8'h00});
      check(32'({relay1_closed, relay2_closed}), 32'h3);
      if (k == 0) ch1_drop <= 1'b1;
      else energise <= 1'b0;
      wt(4);
      check(32'(gate_enable), 32'h0);
      check(32'(drive_run), 32'h0);
      check(32'({relay1_closed, relay2_closed}), (k == 0) ? 32'h1 : 32'h2);
      check(32'(display_req), 32'(STO_DISP_INHIBIT));
      wt(2);
      check(32'(irq), 32'h1);
      axi_rd(STO_REG_STATUS);
      check(32'(st.state), 32'(STO_ST_OFF));
      check(32'(st.inhibit), 32'h1);
      // a mask bit of one lets its status bit reach irq; zero blocks all
      axi_wr(STO_REG_IRQ_MASK, 32'h00000000);
      wt(3);
      check(32'(irq), 32'h0);
      axi_wr(STO_REG_IRQ_MASK, 32'h00000001);
      axi_wr(STO_REG_IRQ_STAT, 32'h00000001);
      wt(3);
      check(32'(irq), 32'h0);
      axi_wr(STO_REG_CTRL, 32'h00000005);
      wt(3);
      check(32'(gate_enable), 32'h0);
      ch1_drop <= 1'b0;
      energise <= 1'b1;
      wt(6);
      axi_rd(STO_REG_STATUS);
      check(32'(st.state), 32'(STO_ST_STANDBY));
      check(32'(drive_run), 32'h0);
    end
    // start from terminal one, then automatic restart after re-energise
    axi_wr(STO_REG_CTRL, 32'h00000010);
    start_inputs <= 4'h1;
    wt(4);
    check(32'(drive_run), 32'h1);
    energise <= 1'b0;
    wt(4);
    check(32'(gate_enable), 32'h0);
    // without mains the inhibit request is withdrawn
    mains_on <= 1'b0;
    wt(2);
    check(32'(display_req), 32'(STO_DISP_NORMAL));
    mains_on <= 1'b1;
    energise <= 1'b1;
    wt(8);
    check(32'(drive_run), 32'h1);
    start_inputs <= 4'h0;
    axi_wr(STO_REG_CTRL, 32'h00000012);
    wt(3);
    check(32'(drive_run), 32'h0);
    check(32'(fault_code), 32'h0);
    axi_rd(8'h20);
    check(32'(rsp), 32'h2);
    axi_wr(8'h24, 32'h00000000);
    check(32'(rsp), 32'h2);
    test_done();
  end
endmodule : tb_sto_ctrl
